// ==== src/monitor_pkg.sv ====
/*
 * Package for the monitor cycle and limit compare block: register offsets,
 * configuration bit positions, reset values, channel order and pacing.
 * Assumes a single 100 MHz clock and a parallel register port.
 */
package monitor_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG       = 8'h40; // monitor_configuration
    localparam logic [7:0] ADDR_VALUE_BASE   = 8'h20; // value registers 20h..27h
    localparam logic [7:0] ADDR_TEMP_VALUE   = 8'h27;
    localparam logic [7:0] ADDR_LIMIT_BASE   = 8'h2B; // high/low pairs from 2Bh
    localparam logic [7:0] ADDR_HOT_LIMIT    = 8'h39;
    localparam logic [7:0] ADDR_HYST_LIMIT   = 8'h3A;
    localparam logic [7:0] ADDR_INT_STATUS   = 8'h41;
    localparam logic [7:0] ADDR_TEMP_CONFIG  = 8'h4B;
    localparam logic [7:0] ADDR_FAN_DAC      = 8'h19;

    // ------------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------------
    localparam int CFG_START_BIT   = 0;
    localparam int CFG_INT_EN_BIT  = 1;
    localparam int CFG_INT_CLR_BIT = 3;
    localparam int TEMP_LSB_BIT    = 7;

    localparam logic [7:0] CONFIG_RESET  = 8'h08;
    localparam logic [7:0] FAN_DAC_RESET = 8'hFF;
    localparam logic [7:0] LIMIT_HI_RST  = 8'hFF;
    localparam logic [7:0] LIMIT_LO_RST  = 8'h00;
    localparam logic [7:0] HOT_RST       = 8'h7F;
    localparam logic [7:0] HYST_RST      = 8'h7F;

    // ------------------------------------------------------------------
    // Channels: six voltages then temperature
    // ------------------------------------------------------------------
    localparam int NUM_CHANNELS  = 7;
    localparam int NUM_VOLTAGES  = 6;
    localparam logic [2:0] CH_FIRST = 3'h0; // core_voltage_2_input
    localparam logic [2:0] CH_TEMP  = 3'h6; // on-chip sensor, last
    localparam int TEMP_WIDTH    = 9;

    // ------------------------------------------------------------------
    // Pacing: 22.5 kHz channel clock from 100 MHz
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int CHAN_CLK_HZ   = 22_500;
    localparam int CHAN_CYCLES   = CLK_HZ / CHAN_CLK_HZ; // 4444 cycles = 44.4 us

    // Register port request, carried as one bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Converter sample handed in by the analog front end
    typedef struct packed {
        logic                  valid;
        logic [TEMP_WIDTH-1:0] code;
    } sample_t;

endpackage : monitor_pkg

// ==== src/limit_ram.sv ====
/*
 * Small register-array memory holding per-channel limits.
 * Read data comes out of a register one cycle after the address.
 * Assumes one writer and one reader in the same clock domain.
 */
module limit_ram #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock; no reset input
    input  wire logic                     ref_clk_in,
    // Write port
    input  wire logic                     we_in,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_in,
    input  wire logic [WIDTH-1:0]         wdata_in,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] raddr_in,
    output logic      [WIDTH-1:0]         rdata_out
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Storage and registered read
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = INIT;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        rdata_out <= mem[raddr_in];
    end

endmodule : limit_ram

// ==== src/monitor_cycle_limit_compare.sv ====
/*
 * Round-robin monitor sequencer with value registers, limit compare,
 * temperature formatting, latched interrupt and fan DAC register.
 * Assumes the converter returns one sample per channel request and
 * that register port strobes are synchronous one-cycle pulses.
 */
// What this block does
// - Temperature result is held as a 9-bit two's complement value.
// - Temperature limit compare uses only the upper eight of nine bits.
// - Upper eight bits read at 27h; LSB reads in bit 7 of 4Bh.
// - Half degree per LSB, -128 to +127, minus half reads all ones.
// - Each voltage has high and low limits; outside either requests interrupt.
// - Hot limit sets over-temperature; it clears only below hysteresis limit.
// - Start bit one with clear bit zero begins the measurement cycle.
// - Interrupt output drives only while the interrupt-enable bit is one.
// - Channels convert one at a time, core voltage 2 first, temperature last.
// - Each completed conversion is stored into its value register automatically.
// - Sequence repeats until software writes zero to the start bit or one to the clear bit.
// - Channel counter steps at 22.5 kHz, 44.4 us per channel, seven channels.
// - Starting monitoring also starts fan measurement, then runs unsynchronised.
// - Unsigned 8-bit register sets the fan-control DAC.
// - Fan DAC register resets to all ones for full fan speed.
// - Voltage results are unsigned 8-bit codes, full scale all ones.
module monitor_cycle_limit_compare
    import monitor_pkg::*;
#(
    parameter int CHAN_PERIOD = CHAN_CYCLES
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    // Register port
    input  wire reg_req_t   reg_req_in,
    output logic      [7:0] reg_rdata_out,
    output logic            reg_rvalid_out,
    // Converter front end
    input  wire sample_t    sample_in,
    output logic      [2:0] mux_sel_out,
    output logic            convert_out,
    // Fan and interrupt
    output logic            fan_start_out,
    output logic      [7:0] fan_dac_out,
    output logic            int_n_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum {IDLE, WAIT_SLOT, CONVERT, STORE, COMPARE} seq_state_t;

    seq_state_t  state;
    logic [7:0]  config_reg;
    logic [7:0]  value_reg [NUM_CHANNELS];
    logic        temp_lsb;
    logic [7:0]  hot_limit;
    logic [7:0]  hyst_limit;
    logic [7:0]  int_status;
    logic        over_temp;
    logic [12:0] pace_cnt;
    logic        chan_tick;
    logic [2:0]  chan;
    logic [3:0]  lim_raddr;
    logic [7:0]  hi_rdata;
    logic [7:0]  lo_rdata;
    logic        hi_we;
    logic        lo_we;
    logic [3:0]  lim_waddr;
    logic [7:0]  lim_off;
    logic        running;

    // Byte offset of an address inside the voltage limit window
    function automatic logic [7:0] limit_off(input logic [7:0] a);
        limit_off = a - ADDR_LIMIT_BASE;
    endfunction : limit_off

    assign running = config_reg[CFG_START_BIT] & ~config_reg[CFG_INT_CLR_BIT];

    // ------------------------------------------------------------------
    // Limit memories: even offsets high limits, odd offsets low limits
    // ------------------------------------------------------------------
    // Offset held on a net so its bits can be selected
    assign lim_off   = limit_off(reg_req_in.addr);
    assign lim_waddr = lim_off[4:1];
    assign hi_we = reg_req_in.wr && reg_req_in.addr >= ADDR_LIMIT_BASE &&
                   lim_off < 8'(2 * NUM_VOLTAGES) && !lim_off[0];
    assign lo_we = reg_req_in.wr && reg_req_in.addr >= ADDR_LIMIT_BASE &&
                   lim_off < 8'(2 * NUM_VOLTAGES) && lim_off[0];
    assign lim_raddr = {1'b0, chan};

    limit_ram #(.DEPTH(16), .WIDTH(8), .INIT(LIMIT_HI_RST)) u_high (
        .ref_clk_in (ref_clk_in),
        .we_in      (hi_we),
        .waddr_in   (lim_waddr),
        .wdata_in   (reg_req_in.wdata),
        .raddr_in   (lim_raddr),
        .rdata_out  (hi_rdata)
    );

    limit_ram #(.DEPTH(16), .WIDTH(8), .INIT(LIMIT_LO_RST)) u_low (
        .ref_clk_in (ref_clk_in),
        .we_in      (lo_we),
        .waddr_in   (lim_waddr),
        .wdata_in   (reg_req_in.wdata),
        .raddr_in   (lim_raddr),
        .rdata_out  (lo_rdata)
    );

    // ------------------------------------------------------------------
    // Configuration, temperature limits and fan DAC writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            config_reg <= CONFIG_RESET;
            hot_limit  <= HOT_RST;
            hyst_limit <= HYST_RST;
        end else if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                ADDR_CONFIG:     config_reg <= reg_req_in.wdata;
                ADDR_HOT_LIMIT:  hot_limit  <= reg_req_in.wdata;
                ADDR_HYST_LIMIT: hyst_limit <= reg_req_in.wdata;
                default: ;
            endcase
        end
    end

    // Fan DAC code is unsigned and passed straight to the converter
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            fan_dac_out <= FAN_DAC_RESET;
        end else if (reg_req_in.wr && reg_req_in.addr == ADDR_FAN_DAC) begin
            fan_dac_out <= reg_req_in.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Channel pacing: one tick per 44.4 us slot
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !running) begin
            pace_cnt  <= '0;
            chan_tick <= 1'b0;
        end else if (pace_cnt == 13'(CHAN_PERIOD - 1)) begin
            pace_cnt  <= '0;
            chan_tick <= 1'b1;
        end else begin
            pace_cnt  <= pace_cnt + 13'h1;
            chan_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer: request, store, compare, step channel
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state       <= IDLE;
            chan        <= CH_FIRST;
            convert_out <= 1'b0;
        end else begin
            convert_out <= 1'b0;
            case (state)
                IDLE: begin
                    chan <= CH_FIRST;
                    if (running) begin
                        state <= WAIT_SLOT;
                    end
                end
                WAIT_SLOT: begin
                    if (!running) begin
                        state <= IDLE;
                    end else if (chan_tick) begin
                        convert_out <= 1'b1;
                        state       <= CONVERT;
                    end
                end
                CONVERT: begin
                    if (sample_in.valid) begin
                        state <= STORE;
                    end
                end
                STORE:   state <= COMPARE; // value register holds the new sample here
                COMPARE: begin
                    // Wrap after the temperature slot so the cycle repeats
                    chan  <= (chan == CH_TEMP) ? CH_FIRST : chan + 3'h1;
                    state <= running ? WAIT_SLOT : IDLE;
                end
                default: state <= IDLE;
            endcase
        end
    end

    // Mux select mirrors the channel counter through a flop
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            mux_sel_out <= CH_FIRST;
        end else begin
            mux_sel_out <= chan;
        end
    end

    // Fan measurement start pulse on the rising edge of monitoring
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            fan_start_out <= 1'b0;
        end else begin
            fan_start_out <= (state == IDLE) && running;
        end
    end

    // ------------------------------------------------------------------
    // Value registers: stored without software action
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                value_reg[i] <= '0;
            end
            temp_lsb <= 1'b0;
        end else if (state == CONVERT && sample_in.valid) begin
            if (chan == CH_TEMP) begin
                value_reg[chan] <= sample_in.code[8:1];
                temp_lsb        <= sample_in.code[0];
            end else begin
                value_reg[chan] <= sample_in.code[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Limit compare and latched interrupt status
    // ------------------------------------------------------------------
    // Set wins over the clear so a hit in the clearing cycle survives
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            int_status <= '0;
            over_temp  <= 1'b0;
        end else begin
            if (config_reg[CFG_INT_CLR_BIT]) begin
                int_status <= '0;
            end
            if (state == COMPARE) begin
                if (chan == CH_TEMP) begin
                    // Signed compare on the upper eight bits only
                    if ($signed(value_reg[CH_TEMP]) > $signed(hot_limit)) begin
                        over_temp         <= 1'b1;
                        int_status[chan]  <= 1'b1;
                    end else if ($signed(value_reg[CH_TEMP]) < $signed(hyst_limit)) begin
                        over_temp <= 1'b0;
                    end else if (over_temp) begin
                        int_status[chan] <= 1'b1;
                    end
                end else if (value_reg[chan] > hi_rdata ||
                             value_reg[chan] < lo_rdata) begin
                    int_status[chan] <= 1'b1;
                end
            end
        end
    end

    // Interrupt pin only driven when enabled, active low
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            int_n_out <= 1'b1;
        end else begin
            int_n_out <= ~(config_reg[CFG_INT_EN_BIT] && |int_status);
        end
    end

    // ------------------------------------------------------------------
    // Register reads, one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out  <= '0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                if (reg_req_in.addr >= ADDR_VALUE_BASE &&
                    reg_req_in.addr <= ADDR_TEMP_VALUE) begin
                    // 20h..25h: voltages, 26h and 27h: temperature upper bits
                    reg_rdata_out <= (reg_req_in.addr == ADDR_TEMP_VALUE) ?
                        value_reg[CH_TEMP] :
                        value_reg[3'(reg_req_in.addr - ADDR_VALUE_BASE)];
                end else begin
                    case (reg_req_in.addr)
                        ADDR_CONFIG:      reg_rdata_out <= config_reg;
                        ADDR_INT_STATUS:  reg_rdata_out <= int_status;
                        ADDR_HOT_LIMIT:   reg_rdata_out <= hot_limit;
                        ADDR_HYST_LIMIT:  reg_rdata_out <= hyst_limit;
                        ADDR_FAN_DAC:     reg_rdata_out <= fan_dac_out;
                        ADDR_TEMP_CONFIG: reg_rdata_out <= {temp_lsb, 7'h00};
                        default:          reg_rdata_out <= 8'h00;
                    endcase
                end
            end
        end
    end

endmodule : monitor_cycle_limit_compare

// ==== dv/monitor_cycle_limit_compare_checker.sv ====
/* Port checker for the monitor sequencer.
   Assumes the bench runs it with a short channel period. */
module monitor_checker
    import monitor_pkg::*;
#(
    parameter int CHAN_PERIOD = 8
) (
    // Clock, reset and register port
    input wire logic       ref_clk_in,
    input wire logic       rst_n_in,
    input wire reg_req_t   reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    // Sequencer and outputs
    input wire logic [2:0] mux_sel_out,
    input wire logic       convert_out,
    input wire logic       fan_start_out,
    input wire logic [7:0] fan_dac_out,
    input wire logic       int_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int START_WAIT = 20;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // --------------------------------
    // Gap since last request; a restart opens a fresh gap
    // --------------------------------
    logic [15:0] gap;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || fan_start_out)
            gap <= 16'hFFFF;
        else if (convert_out)
            gap <= 16'h0000;
        else if (gap != 16'hFFFF)
            gap <= gap + 16'h0001;
    end
    a_read_answer: assert property (reg_req_in.rd |=> reg_rvalid_out)
        else $error("read without answer");
    a_rdata_stands: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
        else $error("read data moved");
    a_convert_pulse: assert property (convert_out |=> !convert_out)
        else $error("convert longer than one cycle");
    a_convert_spacing: assert property (convert_out |-> gap >= 16'(CHAN_PERIOD - 1))
        else $error("conversions too close");
    a_mux_order: assert property ($changed(mux_sel_out) |-> mux_sel_out == CH_FIRST
        || (mux_sel_out == $past(mux_sel_out) + 3'h1 && mux_sel_out <= CH_TEMP))
        else $error("channel order broken");
    a_fan_pulse: assert property (fan_start_out |=> !fan_start_out)
        else $error("fan start longer than one cycle");
    a_fan_with_scan: assert property (fan_start_out |-> ##[0:START_WAIT] convert_out)
        else $error("fan start without channel scan");
    a_reset_values: assert property ($past(!rst_n_in) |-> int_n_out && !convert_out
        && fan_dac_out == FAN_DAC_RESET)
        else $error("wrong value after reset");
    a_dac_by_write: assert property ($changed(fan_dac_out) |-> $past(reg_req_in.wr)
        && $past(reg_req_in.addr) == ADDR_FAN_DAC)
        else $error("fan code moved without write");
endmodule : monitor_checker

bind monitor_cycle_limit_compare monitor_checker #(.CHAN_PERIOD(CHAN_PERIOD)) i_checker (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .mux_sel_out(mux_sel_out), .convert_out(convert_out),
    .fan_start_out(fan_start_out), .fan_dac_out(fan_dac_out), .int_n_out(int_n_out));

// ==== dv/conv_model.sv ====
/* Converter front end model: answers each request after a set delay.
   Assumes the channel select has settled two cycles after a request. */
module conv_model
    import monitor_pkg::*;
(
    // Clock and request
    input  wire logic        ref_clk_in,
    input  wire logic        convert_in,
    input  wire logic [2:0]  mux_sel_in,
    // Answer delay and per-channel codes
    input  wire logic [2:0]  delay_in,
    input  wire logic [62:0] codes_in,
    output sample_t          sample_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt;
    logic       busy;
    initial begin
        busy = 1'b0;
        sample_out = '0;
    end
    // --------------------------------
    // Answer; an idle bus never keeps the last code
    // --------------------------------
    always @(posedge ref_clk_in) begin
        sample_out.valid <= 1'b0;
        sample_out.code <= ~sample_out.code;
        if (convert_in) begin
            busy <= 1'b1;
            wait_cnt <= delay_in;
        end else if (busy && wait_cnt == 3'h0) begin
            busy <= 1'b0;
            sample_out.valid <= 1'b1;
            sample_out.code <= codes_in[mux_sel_in * 9 +: 9];
        end else if (busy)
            wait_cnt <= wait_cnt - 3'h1;
    end
endmodule : conv_model

// ==== dv/monitor_cycle_limit_compare_bench.sv ====
/* Self-checking bench for the monitor sequencer.
   Assumes the converter model and the bound checker. */
module monitor_cycle_limit_compare_bench
    import monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] exp; logic [7:0] mask;} note_t;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    reg_req_t req;
    sample_t sample;
    logic [7:0] rdata, dac;
    logic rvalid, convert, fan_start, int_n;
    logic [2:0] mux, delay;
    logic [62:0] codes;
    int n_fail = 0, n_tests = 0, cycles = 0, n_conv = 0;
    bit fan_seen = 0;
    note_t notes[$];

    monitor_cycle_limit_compare #(.CHAN_PERIOD(8)) i_dut (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .sample_in(sample), .mux_sel_out(mux), .convert_out(convert),
        .fan_start_out(fan_start), .fan_dac_out(dac), .int_n_out(int_n));
    conv_model i_conv (.ref_clk_in(ref_clk_in), .convert_in(convert), .mux_sel_in(mux),
        .delay_in(delay), .codes_in(codes), .sample_out(sample));

    always #5 ref_clk_in = ~ref_clk_in;
    // --------------------------------
    // Compare tasks and register access
    // --------------------------------
    task automatic compare_pin(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : compare_pin
    task automatic compare_read(input logic [7:0] got, input note_t n);
        compare_pin(got & n.mask, n.exp);
    endtask : compare_read
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_in);
        req <= '0;
        @(posedge ref_clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back('{exp: e, mask: m});
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_in);
        req <= '0;
        @(posedge ref_clk_in);
    endtask : rd
    // One full sweep at the slowest converter delay, with a fresh delay
    task automatic settle();
        delay <= 3'(1 + $urandom % 4);
        repeat (140) @(posedge ref_clk_in);
    endtask : settle
    // Clear pulse stops the scan, so monitoring restarts after it
    task automatic clear_int();
        wr(ADDR_CONFIG, 8'h0B);
        wr(ADDR_CONFIG, 8'h03);
    endtask : clear_int

    // Watcher: results, request count and hang limit
    always @(posedge ref_clk_in) begin
        cycles++;
        if (convert === 1'b1) n_conv++;
        if (fan_start === 1'b1) fan_seen = 1;
        if (rvalid === 1'b1) compare_read(rdata, notes.pop_front());
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        logic [7:0] v;
        logic [7:0] cfg [2];
        req = '0;
        delay = 3'h2;
        codes = '0;
        cfg = '{8'h00, 8'h09};
        void'($urandom(32'h5B716035));
        repeat (10) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        rd(ADDR_FAN_DAC, FAN_DAC_RESET, 8'hFF);
        rd(ADDR_CONFIG, CONFIG_RESET, 8'hFF);
        rd(8'h7F, 8'h00, 8'hFF);
        v = 8'($urandom);
        wr(ADDR_FAN_DAC, v);
        rd(ADDR_FAN_DAC, v, 8'hFF);
        compare_pin(dac, v);
        // Limits 40h..C0h; hot +50 C, hysteresis +40 C
        for (int i = 0; i < NUM_VOLTAGES; i++) begin
            wr(ADDR_LIMIT_BASE + 8'(2 * i), 8'hC0);
            wr(ADDR_LIMIT_BASE + 8'(2 * i + 1), 8'h40);
            codes[i * 9 +: 9] <= 9'(8'h80 + i);
        end
        codes[17:0] <= {9'h040, 9'h0C0};
        codes[62:54] <= 9'h1FF;
        wr(ADDR_HOT_LIMIT, 8'h32);
        wr(ADDR_HYST_LIMIT, 8'h28);
        wr(ADDR_CONFIG, 8'h03);
        settle();
        compare_pin({7'h00, fan_seen}, 8'h01);
        for (int i = 0; i < NUM_VOLTAGES; i++)
            rd(ADDR_VALUE_BASE + 8'(i),
               i == 0 ? 8'hC0 : i == 1 ? 8'h40 : 8'(8'h80 + i), 8'hFF);
        rd(ADDR_TEMP_VALUE, 8'hFF, 8'hFF);
        rd(ADDR_TEMP_CONFIG, 8'h80, 8'h80);
        compare_pin({7'h00, int_n}, 8'h01);
        // Half a degree over the hot limit stays quiet
        codes[62:54] <= 9'h065;
        settle();
        rd(ADDR_TEMP_VALUE, 8'h32, 8'hFF);
        rd(ADDR_TEMP_CONFIG, 8'h80, 8'h80);
        compare_pin({7'h00, int_n}, 8'h01);
        // Each voltage above high, then below low
        for (int i = 0; i < 2 * NUM_VOLTAGES; i++) begin
            codes[(i / 2) * 9 +: 9] <= (i % 2) ? 9'h03F : 9'h0C1;
            settle();
            compare_pin({7'h00, int_n}, 8'h00);
            codes[(i / 2) * 9 +: 9] <= 9'(8'h80 + i / 2);
            settle();
            compare_pin({7'h00, int_n}, 8'h00);
            clear_int();
            settle();
            compare_pin({7'h00, int_n}, 8'h01);
        end
        // Output held off while disabled, pending once enabled
        wr(ADDR_CONFIG, 8'h01);
        codes[26:18] <= 9'h0FF;
        settle();
        compare_pin({7'h00, int_n}, 8'h01);
        codes[26:18] <= 9'h082;
        wr(ADDR_CONFIG, 8'h03);
        repeat (20) @(posedge ref_clk_in);
        compare_pin({7'h00, int_n}, 8'h00);
        // Over-temperature with hysteresis; the pending voltage hit is
        // cleared first, and each clear waits a sweep of the new code so
        // a stale temperature compare cannot land on the clear
        clear_int();
        repeat (2) @(posedge ref_clk_in);
        compare_pin({7'h00, int_n}, 8'h01);
        codes[62:54] <= 9'h078;
        settle();
        compare_pin({7'h00, int_n}, 8'h00);
        codes[62:54] <= 9'h05A;
        settle();
        clear_int();
        settle();
        compare_pin({7'h00, int_n}, 8'h00);
        codes[62:54] <= 9'h032;
        settle();
        clear_int();
        settle();
        compare_pin({7'h00, int_n}, 8'h01);
        // Stop bit and held clear bit both halt the scan
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CONFIG, cfg[k]);
            repeat (20) @(posedge ref_clk_in);
            n_conv = 0;
            repeat (100) @(posedge ref_clk_in);
            compare_pin(8'(n_conv), 8'h00);
            wr(ADDR_CONFIG, 8'h03);
            settle();
        end
        test_done();
    end
endmodule : monitor_cycle_limit_compare_bench
